// ===== hdl/spmc_rx_filter.sv
// Receive frame length checker: oversize and length field mismatch
`timescale 1ns/10ps
`include "spmc_defs.svh"
module spmc_rx_filter
   import spmc_pkg::*;
#(
   parameter int LW = 14
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Configuration
   input wire logic [LW-1:0] max_len_i,
   input wire logic len_check_i,
   // Byte stream
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_last_i,
   // Verdict
   output logic frame_ok_o,
   output logic frame_drop_o,
   output logic drop_oversize_o
);

   logic [LW-1:0] cnt;
   logic [15:0] len_field;
   logic [LW-1:0] total;
   logic [LW-1:0] payload;
   logic oversize;
   logic mismatch;

   // ==================================================================
   // Byte counter, saturating so giant frames still read as oversize
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
      end else if (rx_valid_i) begin
         if (rx_last_i) begin
            cnt <= '0;
         end else if (cnt != '1) begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         len_field <= '0;
      end else if (rx_valid_i && cnt == `SPMC_LEN_HI_POS) begin
         len_field[15:8] <= rx_data_i;
      end else if (rx_valid_i && cnt == `SPMC_LEN_LO_POS) begin
         len_field[7:0] <= rx_data_i;
      end
   end

   // ==================================================================
   // Verdict on the last byte
   always_comb begin
      total = (cnt == '1) ? cnt : cnt + 1'b1;
      payload = (total > `SPMC_HDR_FCS) ? total - `SPMC_HDR_FCS : '0;
      oversize = total > max_len_i;
      mismatch = 1'b0;
      // Field at or above 1536 is a type, never checked
      if (len_check_i && len_field < `SPMC_TYPE_MIN) begin
         // Short payloads carry padding, so only an overstated length fails
         if (payload > `SPMC_MIN_PAYLOAD) begin
            mismatch = len_field[LW-1:0] != payload
                       || len_field[15:LW] != '0;
         end else begin
            mismatch = len_field > {2'h0, payload};
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         frame_ok_o <= 1'b0;
         frame_drop_o <= 1'b0;
         drop_oversize_o <= 1'b0;
      end else begin
         frame_ok_o <= rx_valid_i && rx_last_i && !oversize && !mismatch;
         frame_drop_o <= rx_valid_i && rx_last_i && (oversize || mismatch);
         // Only oversize drops are counted
         drop_oversize_o <= rx_valid_i && rx_last_i && oversize;
      end
   end

endmodule

// ===== hdl/spmc_top.sv
// Per-port MAC configuration: speed, media, flow control, aggregation
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "spmc_defs.svh"
module spmc_top
   import spmc_pkg::*;
#(
   parameter int LW = 14,
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // PHY and module reader pins
   input wire spmc_pin_type pins_i,
   // Transmit MAC events
   input wire logic tx_start_i,
   input wire logic tx_col_i,
   // Receive byte stream
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_last_i,
   // Link and advertisement
   output spmc_link_type link_o,
   output logic [2:0] adv_speed_o,
   output logic [1:0] adv_duplex_o,
   output logic adv_pause_o,
   // Flow control
   output logic pause_rx_en_o,
   output logic pause_tx_en_o,
   output logic pfc_en_o,
   output logic [7:0] pfc_prio_o,
   // Transmit collision handling
   output logic tx_abort_o,
   output logic tx_backoff_restart_o,
   // Receive verdict
   output logic rx_frame_ok_o,
   output logic rx_frame_drop_o,
   // Aggregation
   output logic [3:0] hash_sel_o,
   output logic [3:0] aggr_group_o,
   output logic aggr_member_o
);

   localparam int PW = $bits(spmc_pin_type);

   spmc_speed_type speed_cfg;
   logic [1:0] adv_dup;
   logic [2:0] adv_spd;
   logic fc_en;
   logic pfc_en;
   logic excol_restart;
   logic len_check;
   logic [LW-1:0] max_len;
   logic [7:0] pfc_prio;
   logic [3:0] hash_sel;
   logic [3:0] group;
   logic [CW-1:0] drop_cnt;
   logic [4:0] col_cnt;
   logic [PW-1:0] pin_meta;
   logic [PW-1:0] pin_sync;
   spmc_pin_type pin;
   spmc_link_type next_link;
   logic next_pause_rx;
   logic next_pause_tx;
   logic [2:0] common_spd;
   logic [1:0] common_dup;
   logic [31:0] next_prdata;
   logic mapped;
   logic wr_en;
   logic drop_oversize;
   logic next_abort;
   logic next_restart;

   // ==================================================================
   // Pin synchronisers
   generate
      for (genvar i = 0; i < PW; i++) begin : g_sync
         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               pin_meta[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
            end else begin
               pin_meta[i] <= pins_i[i];
               pin_sync[i] <= pin_meta[i];
            end
         end
      end
   endgenerate

   assign pin = spmc_pin_type'(pin_sync);

   // ==================================================================
   // APB decode
   always_comb begin
      mapped = 1'b1;
      next_prdata = '0;
      unique case (paddr_i)
         `SPMC_OFF_CTRL: begin
            next_prdata[`SPMC_F_SPEED] = speed_cfg;
            next_prdata[`SPMC_F_ADV_DUP] = adv_dup;
            next_prdata[`SPMC_F_ADV_SPD] = adv_spd;
            next_prdata[`SPMC_B_FC] = fc_en;
            next_prdata[`SPMC_B_PFC] = pfc_en;
            next_prdata[`SPMC_B_EXCOL] = excol_restart;
            next_prdata[`SPMC_B_LENCHK] = len_check;
         end
         `SPMC_OFF_MAXFRM: next_prdata[`SPMC_F_MAXFRM] = max_len;
         `SPMC_OFF_PFC: next_prdata[`SPMC_F_PRIO] = pfc_prio;
         `SPMC_OFF_AGGR: begin
            next_prdata[`SPMC_F_HASH] = hash_sel;
            next_prdata[`SPMC_F_GROUP] = group;
         end
         `SPMC_OFF_STATUS: begin
            next_prdata[7:0] = link_o;
            next_prdata[8] = pause_rx_en_o;
            next_prdata[9] = pause_tx_en_o;
            next_prdata[10] = aggr_member_o;
            next_prdata[15:11] = col_cnt;
         end
         `SPMC_OFF_DROPCNT: next_prdata[CW-1:0] = drop_cnt;
         default: mapped = 1'b0;
      endcase
   end

   // Zero wait: the answer is ready in the first access cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped;
         if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= next_prdata;
         end
      end
   end

   assign wr_en = psel_i && penable_i && pready_o && pwrite_i && mapped;

   // ==================================================================
   // Control register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         speed_cfg <= spmc_speed_type'(`SPMC_RST_SPEED);
         adv_dup <= `SPMC_RST_ADV_DUP;
         adv_spd <= `SPMC_RST_ADV_SPD;
         fc_en <= 1'b0;
         pfc_en <= 1'b0;
         excol_restart <= 1'b0;
         len_check <= 1'b0;
      end else if (wr_en && paddr_i == `SPMC_OFF_CTRL) begin
         // Unknown speed codes are ignored, keeping the last good one
         if (pwdata_i[`SPMC_F_SPEED] <= SPD_FIBRE_1000) begin
            speed_cfg <= spmc_speed_type'(pwdata_i[`SPMC_F_SPEED]);
         end
         adv_dup <= pwdata_i[`SPMC_F_ADV_DUP];
         adv_spd <= pwdata_i[`SPMC_F_ADV_SPD];
         fc_en <= pwdata_i[`SPMC_B_FC];
         // Pause wins when both are asked
         pfc_en <= pwdata_i[`SPMC_B_PFC] && !pwdata_i[`SPMC_B_FC];
         excol_restart <= pwdata_i[`SPMC_B_EXCOL];
         len_check <= pwdata_i[`SPMC_B_LENCHK];
      end
   end

   // ==================================================================
   // Maximum frame size, clamped into the legal range
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         max_len <= `SPMC_MAXFRM_MIN;
      end else if (wr_en && paddr_i == `SPMC_OFF_MAXFRM) begin
         if (pwdata_i[31:LW] != '0
             || pwdata_i[`SPMC_F_MAXFRM] > `SPMC_MAXFRM_MAX) begin
            max_len <= `SPMC_MAXFRM_MAX;
         end else if (pwdata_i[`SPMC_F_MAXFRM] < `SPMC_MAXFRM_MIN) begin
            max_len <= `SPMC_MAXFRM_MIN;
         end else begin
            max_len <= pwdata_i[`SPMC_F_MAXFRM];
         end
      end
   end

   // ==================================================================
   // Priority set and aggregation
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pfc_prio <= '0;
      end else if (wr_en && paddr_i == `SPMC_OFF_PFC) begin
         pfc_prio <= pwdata_i[`SPMC_F_PRIO];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hash_sel <= `SPMC_RST_HASH;
         group <= `SPMC_RST_GROUP;
      end else if (wr_en && paddr_i == `SPMC_OFF_AGGR) begin
         hash_sel <= pwdata_i[`SPMC_F_HASH];
         // One field holds one group id, zero is no group
         group <= pwdata_i[`SPMC_F_GROUP];
      end
   end

   // ==================================================================
   // Speed, duplex and media resolution
   always_comb begin
      common_spd = adv_spd & pin.partner_speed;
      common_dup = adv_dup & pin.partner_duplex;
      next_link = '0;
      next_pause_rx = 1'b0;
      next_pause_tx = 1'b0;
      unique case (speed_cfg)
         SPD_DISABLED: next_link = '0;
         SPD_AUTO, SPD_MOD_AUTO: begin
            next_link.port_en = 1'b1;
            next_link.copper_en = 1'b1;
            next_link.copper_auto = 1'b1;
            next_link.link_up = pin.an_done && common_spd != '0
                                && common_dup != '0;
            next_link.full_dup = common_dup[1];
            // Highest common speed wins
            if (common_spd[2]) begin
               next_link.rate = RATE_1G;
            end else if (common_spd[1]) begin
               next_link.rate = RATE_100;
            end else begin
               next_link.rate = RATE_10;
            end
            // Pause follows the last negotiation result
            next_pause_rx = pin.an_done && pin.an_pause_rx;
            next_pause_tx = pin.an_done && pin.an_pause_tx;
            // Module speed from its ID memory takes the fibre side
            if (speed_cfg == SPD_MOD_AUTO && pin.mod_valid) begin
               next_link.fiber_en = 1'b1;
               next_link.rate = pin.mod_rate;
               next_link.full_dup = 1'b1;
               next_link.link_up = pin.link_sense;
               next_pause_rx = fc_en && pin.mod_rate != RATE_100;
               next_pause_tx = fc_en && pin.mod_rate != RATE_100;
            end
         end
         SPD_10_HALF, SPD_10_FULL, SPD_100_HALF, SPD_100_FULL,
         SPD_1G_FULL: begin
            next_link.port_en = 1'b1;
            next_link.copper_en = 1'b1;
            next_link.link_up = pin.link_sense;
            next_link.full_dup = speed_cfg[0] || speed_cfg == SPD_1G_FULL;
            next_link.rate = (speed_cfg == SPD_1G_FULL) ? RATE_1G :
                             (speed_cfg[2]) ? RATE_100 : RATE_10;
            next_pause_rx = fc_en;
            next_pause_tx = fc_en;
         end
         SPD_2G5_FULL: begin
            next_link.port_en = 1'b1;
            next_link.fiber_en = 1'b1;
            next_link.link_up = pin.link_sense;
            next_link.full_dup = 1'b1;
            next_link.rate = RATE_2G5;
            next_pause_rx = fc_en;
            next_pause_tx = fc_en;
         end
         SPD_FIBRE_100, SPD_FIBRE_1000: begin
            // Optical port only, copper held off
            next_link.port_en = 1'b1;
            next_link.fiber_en = 1'b1;
            next_link.link_up = pin.link_sense;
            next_link.full_dup = 1'b1;
            next_link.rate = (speed_cfg == SPD_FIBRE_100) ? RATE_100
                                                          : RATE_1G;
            // 100 Mb/s fibre cannot negotiate pause
            next_pause_rx = fc_en && speed_cfg == SPD_FIBRE_1000;
            next_pause_tx = fc_en && speed_cfg == SPD_FIBRE_1000;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         link_o <= '0;
         pause_rx_en_o <= 1'b0;
         pause_tx_en_o <= 1'b0;
         adv_speed_o <= '0;
         adv_duplex_o <= '0;
         adv_pause_o <= 1'b0;
         pfc_en_o <= 1'b0;
         pfc_prio_o <= '0;
      end else begin
         link_o <= next_link;
         // Link pause is never active alongside priority pause
         pause_rx_en_o <= next_pause_rx && !pfc_en;
         pause_tx_en_o <= next_pause_tx && !pfc_en;
         adv_speed_o <= adv_spd;
         adv_duplex_o <= adv_dup;
         // Priority pause is never advertised, only link pause
         adv_pause_o <= fc_en;
         pfc_en_o <= pfc_en && next_link.port_en;
         pfc_prio_o <= next_link.port_en && pfc_en ? pfc_prio : '0;
      end
   end

   // ==================================================================
   // Excessive collisions
   always_comb begin
      next_abort = 1'b0;
      next_restart = 1'b0;
      if (tx_col_i && col_cnt + 5'h01 == `SPMC_COLL_LIMIT) begin
         next_abort = !excol_restart;
         next_restart = excol_restart;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         col_cnt <= '0;
      end else if (tx_start_i || next_abort || next_restart) begin
         col_cnt <= '0;
      end else if (tx_col_i) begin
         col_cnt <= col_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_abort_o <= 1'b0;
         tx_backoff_restart_o <= 1'b0;
      end else begin
         tx_abort_o <= next_abort;
         tx_backoff_restart_o <= next_restart;
      end
   end

   // ==================================================================
   // Receive length checks and the oversize drop counter
   spmc_rx_filter #(
      .LW(LW)
   ) u_rx_filter (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .max_len_i(max_len),
      .len_check_i(len_check),
      .rx_valid_i(rx_valid_i),
      .rx_data_i(rx_data_i),
      .rx_last_i(rx_last_i),
      .frame_ok_o(rx_frame_ok_o),
      .frame_drop_o(rx_frame_drop_o),
      .drop_oversize_o(drop_oversize)
   );

   // A write clears; a drop in the same cycle still counts
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         drop_cnt <= '0;
      end else if (wr_en && paddr_i == `SPMC_OFF_DROPCNT) begin
         drop_cnt <= {{(CW-1){1'b0}}, drop_oversize};
      end else if (drop_oversize && drop_cnt != '1) begin
         drop_cnt <= drop_cnt + 1'b1;
      end
   end

   // ==================================================================
   // Aggregation outputs
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hash_sel_o <= `SPMC_RST_HASH;
         aggr_group_o <= `SPMC_RST_GROUP;
         aggr_member_o <= 1'b0;
      end else begin
         hash_sel_o <= hash_sel;
         aggr_group_o <= group;
         // Half duplex ports never join; membership needs only a nonzero
         // group, port_en and full_dup, with no rate compare between members
         aggr_member_o <= group != '0 && next_link.port_en
                          && next_link.full_dup;
      end
   end

endmodule

// ===== shared/spmc_defs.svh
// Register map, field layout, reset values and frame limits of the port
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH

// ==================================================================
// Register offsets
`define SPMC_OFF_CTRL 8'h00
`define SPMC_OFF_MAXFRM 8'h04
`define SPMC_OFF_PFC 8'h08
`define SPMC_OFF_AGGR 8'h0c
`define SPMC_OFF_STATUS 8'h10
`define SPMC_OFF_DROPCNT 8'h14

// ==================================================================
// Fields of the control, frame size, priority and aggregation registers
`define SPMC_F_SPEED 3:0
`define SPMC_F_ADV_DUP 5:4
`define SPMC_F_ADV_SPD 8:6
`define SPMC_B_FC 9
`define SPMC_B_PFC 10
`define SPMC_B_EXCOL 11
`define SPMC_B_LENCHK 12
`define SPMC_F_MAXFRM 13:0
`define SPMC_F_PRIO 7:0
`define SPMC_F_HASH 3:0
`define SPMC_F_GROUP 7:4

// ==================================================================
// Reset values
`define SPMC_RST_SPEED 4'h1
`define SPMC_RST_ADV_DUP 2'h3
`define SPMC_RST_ADV_SPD 3'h7
`define SPMC_RST_HASH 4'hd
`define SPMC_RST_GROUP 4'h0

// ==================================================================
// Frame and collision limits
`define SPMC_MAXFRM_MIN 14'h5ee
`define SPMC_MAXFRM_MAX 14'h2800
`define SPMC_TYPE_MIN 16'h0600
`define SPMC_HDR_FCS 14'h12
`define SPMC_MIN_PAYLOAD 14'h2e
`define SPMC_LEN_HI_POS 14'hc
`define SPMC_LEN_LO_POS 14'hd
`define SPMC_COLL_LIMIT 5'h10

`endif

// ===== shared/spmc_pkg.sv
// Types shared by the port configuration logic
package spmc_pkg;

   // ===============================================================
   // Configured link speed
   typedef enum logic [3:0] {
      SPD_DISABLED = 4'b0000,
      SPD_AUTO = 4'b0001,
      SPD_10_HALF = 4'b0010,
      SPD_10_FULL = 4'b0011,
      SPD_100_HALF = 4'b0100,
      SPD_100_FULL = 4'b0101,
      SPD_1G_FULL = 4'b0110,
      SPD_2G5_FULL = 4'b0111,
      SPD_MOD_AUTO = 4'b1000,
      SPD_FIBRE_100 = 4'b1001,
      SPD_FIBRE_1000 = 4'b1010
   } spmc_speed_type;

   // ===============================================================
   // Operating rate
   typedef enum logic [1:0] {
      RATE_10 = 2'b00,
      RATE_100 = 2'b01,
      RATE_1G = 2'b10,
      RATE_2G5 = 2'b11
   } spmc_rate_type;

   // ===============================================================
   // Link state pins from the PHY and module reader
   typedef struct packed {
      logic link_sense;
      logic an_done;
      logic an_pause_rx;
      logic an_pause_tx;
      logic [2:0] partner_speed;
      logic [1:0] partner_duplex;
      logic mod_valid;
      spmc_rate_type mod_rate;
   } spmc_pin_type;

   // ===============================================================
   // Resolved port state
   typedef struct packed {
      logic port_en;
      logic link_up;
      logic copper_en;
      logic copper_auto;
      logic fiber_en;
      logic full_dup;
      spmc_rate_type rate;
   } spmc_link_type;

endpackage

// ===== test/spmc_assertions.sv
// Concurrent checks on the port configuration block
`timescale 1ns/10ps
module spmc_checker
   import spmc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic tx_start_i,
   input wire logic tx_col_i,
   input wire logic rx_valid_i,
   input wire logic rx_last_i,
   input wire spmc_link_type link_o,
   input wire logic pause_rx_en_o,
   input wire logic pause_tx_en_o,
   input wire logic pfc_en_o,
   input wire logic [7:0] pfc_prio_o,
   input wire logic tx_abort_o,
   input wire logic tx_backoff_restart_o,
   input wire logic rx_frame_ok_o,
   input wire logic rx_frame_drop_o,
   input wire logic [3:0] aggr_group_o,
   input wire logic aggr_member_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic [4:0] ncol;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || tx_start_i) ncol <= 5'h00;
      else if (tx_col_i) ncol <= ncol == 5'h0f ? 5'h00 : ncol + 5'h01;
   end
   sequence s_last; rx_valid_i && rx_last_i; endsequence
   sequence s_verdict; rx_frame_ok_o ^ rx_frame_drop_o; endsequence
   a_verdict_follows: assert property (s_last |=> s_verdict)
      else $error("no single verdict after last byte");
   a_verdict_cause: assert property
      ((rx_frame_ok_o || rx_frame_drop_o) |-> $past(rx_valid_i && rx_last_i))
      else $error("verdict without a frame end");
   a_sixteen_cols: assert property (tx_col_i && !tx_start_i &&
      ncol == 5'h0f |=> tx_abort_o ^ tx_backoff_restart_o)
      else $error("no action after sixteen collisions");
   a_no_early_abort: assert property
      ((tx_abort_o || tx_backoff_restart_o)
      |-> $past(ncol) == 5'h0f && $past(tx_col_i))
      else $error("collision action before sixteen");
   a_pause_pfc_excl: assert property (pfc_en_o |->
      !pause_rx_en_o && !pause_tx_en_o) else $error("pause with pfc");
   a_prio_off: assert property (!pfc_en_o |-> pfc_prio_o == 8'h00)
      else $error("priorities shown with pfc off");
   a_member_full: assert property (aggr_member_o |->
      link_o.full_dup && aggr_group_o != 4'h0) else $error("bad member");
   a_reset_nogroup: assert property ($rose(rst_n_i) |->
      aggr_group_o == 4'h0 && !aggr_member_o) else $error("group at reset");
endmodule
bind spmc_top spmc_checker u_chk (.clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i), .tx_start_i(tx_start_i), .tx_col_i(tx_col_i),
   .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .link_o(link_o),
   .pause_rx_en_o(pause_rx_en_o), .pause_tx_en_o(pause_tx_en_o),
   .pfc_en_o(pfc_en_o), .pfc_prio_o(pfc_prio_o), .tx_abort_o(tx_abort_o),
   .tx_backoff_restart_o(tx_backoff_restart_o),
   .rx_frame_ok_o(rx_frame_ok_o), .rx_frame_drop_o(rx_frame_drop_o),
   .aggr_group_o(aggr_group_o), .aggr_member_o(aggr_member_o));

// ===== test/spmc_link_peer.sv
// Link partner model: link state pins and receive byte stream
`timescale 1ns/10ps
module spmc_link_peer
   import spmc_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Toward the port
   output spmc_pin_type pins_o,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_last_o
);
   initial begin
      rx_valid_o = 1'h0;
      rx_data_o = 8'h00;
      rx_last_o = 1'h0;
   end
   // Idle data is the inverse of the last byte, never a stale copy
   task automatic send(input int n, input logic [15:0] fld);
      for (int i = 0; i < n; i++) begin
         rx_valid_o <= 1'h1;
         rx_last_o <= (i == n - 1);
         rx_data_o <= i == 12 ? fld[15:8] : i == 13 ? fld[7:0] : 8'(i);
         @(posedge clk_sys_i);
      end
      rx_valid_o <= 1'h0;
      rx_last_o <= 1'h0;
      rx_data_o <= ~rx_data_o;
   endtask
endmodule

// ===== test/test_spmc_top.sv
// Self-checking bench for the port configuration block
`timescale 1ns/10ps
module test_spmc_top
   import spmc_pkg::*;
;
   logic clk_sys_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
   logic [7:0] pa = 8'h00, rdat, pp;
   logic [31:0] pwd = 32'h0, rd, prd;
   logic tx_s = 0, tx_c = 0, ok, drop, err, rdy, slv, rv, rl;
   logic prx, ptx, pfc, ab, rs, rok, rdr, mem, ap;
   logic [3:0] hs, grp, g, h;
   logic [2:0] asp;
   logic [1:0] adu;
   spmc_pin_type pins;
   spmc_link_type lk;
   int miscompares = 0, checks = 0;
   integer seed = 32'h623e;
   always #25 clk_sys_i = ~clk_sys_i;
   spmc_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(rdy), .pslverr_o(slv), .pins_i(pins),
      .tx_start_i(tx_s), .tx_col_i(tx_c), .rx_valid_i(rv),
      .rx_data_i(rdat), .rx_last_i(rl), .link_o(lk), .adv_speed_o(asp),
      .adv_duplex_o(adu), .adv_pause_o(ap), .pause_rx_en_o(prx),
      .pause_tx_en_o(ptx), .pfc_en_o(pfc), .pfc_prio_o(pp),
      .tx_abort_o(ab), .tx_backoff_restart_o(rs), .rx_frame_ok_o(rok),
      .rx_frame_drop_o(rdr), .hash_sel_o(hs), .aggr_group_o(grp),
      .aggr_member_o(mem));
   spmc_link_peer peer (.clk_sys_i(clk_sys_i), .pins_o(pins),
      .rx_valid_o(rv), .rx_data_o(rdat), .rx_last_o(rl));
   // ==================================================================
   // Shared tasks
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Holds the request until pready is seen; a stuck slave ends the run
   task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
      int n = 0;
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_sys_i) pen <= 1'h1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (rdy !== 1'h1 && n < 9);
      rd = prd;
      err = slv;
      if (n == 9) begin
         miscompares++;
         end_sim();
      end
      psel <= 1'h0;
      pen <= 1'h0;
      // One idle edge so the next call never re-raises psel in this step
      @(posedge clk_sys_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic frame(input int n, input logic [15:0] f, input logic e);
      ok = 0;
      drop = 0;
      peer.send(n, f);
      repeat (3) begin
         @(posedge clk_sys_i);
         ok |= rok;
         drop |= rdr;
      end
      chk({ok, drop}, {e, ~e});
   endtask
   task automatic coll(input logic restart);
      ok = 0;
      drop = 0;
      tx_s <= 1'h1;
      @(posedge clk_sys_i) tx_s <= 1'h0;
      tx_c <= 1'h1;
      cyc(16);
      tx_c <= 1'h0;
      repeat (3) begin
         @(posedge clk_sys_i);
         ok |= ab;
         drop |= rs;
      end
      chk({ok, drop}, {~restart, restart});
   endtask
   // ==================================================================
   // Main sequence
   initial begin
      peer.pins_o <= 12'he76;
      cyc(10);
      rst_n_i <= 1'h1;
      cyc(1);
      rdc(8'h00, 32'h1f1);
      rdc(8'h04, 32'h5ee);
      rdc(8'h0c, 32'hd);
      apb(1'h0, 8'h40, 32'h0);
      chk(err, 32'h1);
      apb(1'h1, 8'h04, 32'h100);
      rdc(8'h04, 32'h5ee);
      apb(1'h1, 8'h04, 32'hffff);
      rdc(8'h04, 32'h2800);
      apb(1'h1, 8'h04, 32'h5ee);
      frame(1518, 16'h0800, 1'h1);
      frame(1519, 16'h0800, 1'h0);
      rdc(8'h14, 32'h1);
      apb(1'h1, 8'h00, 32'h11f1);
      frame(100, 16'h0052, 1'h1);
      frame(100, 16'h0051, 1'h0);
      frame(100, 16'h05ff, 1'h0);
      frame(100, 16'h0600, 1'h1);
      rdc(8'h14, 32'h1);
      apb(1'h1, 8'h00, 32'h1f1);
      frame(100, 16'h0051, 1'h1);
      coll(1'h0);
      apb(1'h1, 8'h00, 32'h9f1);
      coll(1'h1);
      g = 4'($random(seed));
      apb(1'h1, 8'h08, {24'h0, g, ~g});
      apb(1'h1, 8'h00, 32'h7f5);
      cyc(4);
      chk({pfc, prx, ptx, ap}, 4'h7);
      apb(1'h1, 8'h00, 32'h5f5);
      cyc(4);
      chk({pfc, pp, prx}, {1'h1, g, ~g, 1'h0});
      for (int c = 2; c < 8; c++) begin
         apb(1'h1, 8'h00, 32'h3f0 | c);
         cyc(4);
         chk({lk.port_en, lk.full_dup, lk.rate, prx, ptx}, {1'h1,
            c[0] | (c == 6), 2'(c < 6 ? (c - 2) / 2 : c - 4), 2'h3});
      end
      apb(1'h1, 8'h00, 32'h3f9);
      cyc(4);
      chk({lk.copper_en, lk.fiber_en, lk.rate, prx, ptx}, 6'h14);
      apb(1'h1, 8'h00, 32'h1f8);
      cyc(4);
      chk({lk.fiber_en, lk.rate}, {1'h1, RATE_1G});
      apb(1'h1, 8'h00, 32'h1f0);
      cyc(4);
      chk(lk.port_en, 32'h0);
      apb(1'h1, 8'h00, 32'h1f1);
      cyc(4);
      chk({lk.rate, lk.full_dup, prx, ptx}, {RATE_100, 3'h6});
      rdc(8'h10, 32'h1f5);
      apb(1'h1, 8'h00, 32'h91);
      cyc(4);
      chk({asp, adu}, 5'h09);
      apb(1'h1, 8'h00, 32'h1f6);
      for (int i = 0; i < 6; i++) begin
         g = i == 0 ? 4'h0 : 4'($random(seed)) | 4'h1;
         h = 4'($random(seed));
         apb(1'h1, 8'h0c, {24'h0, g, h});
         cyc(4);
         chk({hs, grp, mem}, {h, g, g != 4'h0});
      end
      apb(1'h1, 8'h00, 32'h1f2);
      cyc(4);
      chk(mem, 32'h0);
      end_sim();
   end
endmodule
